// ==== bgc_top.sv ====
// Boolean gate cycle evaluator: connectors, flags and basic gates
// Notes on behaviour
// - AND output high only when all inputs high.
// - Open AND/NAND inputs, edge variants too, read as one.
// - Edge AND high when all high now and one was low before.
// - NAND output low only when all four inputs high.
// - Edge NAND high when one low now and all were high before.
// - OR output high when any input high.
// - Open OR inputs read as zero.
// - Each gate input can be inverted before evaluation.
// - Gates take exactly four inputs, numbered one to four.
// - Startup flag high in the first run cycle, then cleared.
// - After the first cycle the startup flag is an ordinary flag.
// - Flag outputs show last cycle's input, stable during the cycle.
// - Twenty-four digital and six analog flags forward their inputs.
// - Eight shift bits are read-only sources to the gates.
// - Constant one and zero levels connect to any gate input.
// - Digital inputs numbered base unit first, then expansions in order.
// - Up to sixteen outputs numbered base first, then expansions.
// - Sixteen blank outputs are sinks, not readable as sources.
// - Terminals seven and eight read digital or analog as selected.
// - Four cursor keys act as ordinary digital inputs.
// - NOR high only when all inputs low; open inputs read zero.
`timescale 1ns/10ps
module bgc_top
    import bgc_pkg::*;
(
    // Clock and reset
    input  wire logic                                  core_clk_i,
    input  wire logic                                  reset_i,
    // Program cycle control
    input  wire logic                                  run_i,
    input  wire logic                                  cycle_i,
    // Gate configuration
    input  wire bgc_gate_cfg_s [NUM_GATES-1:0]         gate_cfg_i,
    // Terminal pins, base unit and expansion modules
    input  wire logic [NUM_BASE_INS-1:0]               base_in_i,
    input  wire logic [NUM_EXP_INS-1:0]                exp_in_i,
    input  wire logic [NUM_CURSOR-1:0]                 cursor_i,
    input  wire logic [1:0]                            analog_sel_i,
    input  wire logic [1:0][ANA_WIDTH-1:0]             analog_pin_i,
    // Shift register function contents
    input  wire logic [NUM_SHIFT_BITS-1:0]             shift_bits_i,
    // Flag inputs
    input  wire logic [NUM_DIG_FLAGS-1:0]              flag_src_sel_i,
    input  wire bgc_flag_wr_s                          flag_wr_i,
    input  wire logic [NUM_ANA_FLAGS-1:0][ANA_WIDTH-1:0] ana_flag_in_i,
    // Output routing
    input  wire logic [NUM_DIG_OUTS-1:0][1:0]          out_gate_sel_i,
    input  wire logic [NUM_BLANK_OUTS-1:0][1:0]        blank_gate_sel_i,
    // Results
    output logic [NUM_GATES-1:0]                       gate_out_o,
    output logic [NUM_BASE_OUTS-1:0]                   base_out_o,
    output logic [NUM_DIG_OUTS-NUM_BASE_OUTS-1:0]      exp_out_o,
    output logic [NUM_DIG_FLAGS-1:0]                   flags_o,
    output logic [NUM_ANA_FLAGS-1:0][ANA_WIDTH-1:0]    ana_flags_o,
    output logic [1:0][ANA_WIDTH-1:0]                  analog_ch_o,
    output logic                                       first_cycle_pulse_o,
    output bgc_run_e                                   run_state_o
);

    // All registered state
    typedef struct packed {
        logic [NUM_BASE_INS-1:0]                  base_m;
        logic [NUM_BASE_INS-1:0]                  base_s;
        logic [NUM_EXP_INS-1:0]                   exp_m;
        logic [NUM_EXP_INS-1:0]                   exp_s;
        logic [NUM_CURSOR-1:0]                    cur_m;
        logic [NUM_CURSOR-1:0]                    cur_s;
        logic [1:0][ANA_WIDTH-1:0]                ana_m;
        logic [1:0][ANA_WIDTH-1:0]                ana_p;
        logic [1:0][ANA_WIDTH-1:0]                ana_q;
        logic [1:0][ANA_WIDTH-1:0]                ana_s;
        logic [NUM_DIG_FLAGS-1:0]                 flags;
        logic [NUM_ANA_FLAGS-1:0][ANA_WIDTH-1:0]  aflags;
        logic [NUM_DIG_OUTS-1:0]                  outs;
        logic [NUM_BLANK_OUTS-1:0]                blank;
        logic [1:0][ANA_WIDTH-1:0]                ach;
        bgc_run_e                                 run;
    } bgc_top_st_s;

    bgc_top_st_s                         st_q;
    bgc_top_st_s                         st_d;
    logic [SRC_N-1:0]                    src_vec;
    logic [NUM_DIG_INS-1:0]              dig_ins;
    logic [NUM_GATES-1:0]                gate_q;
    logic [NUM_GATES-1:0][GATE_INPUTS-1:0] gin;
    logic [NUM_GATES-1:0][GATE_INPUTS-1:0] gopen;
    logic [NUM_DIG_FLAGS-1:0]            flag_next;
    logic                                first_cycle;

    // Digital input numbering: base terminals first, then expansions
    always_comb begin
        dig_ins = {st_q.exp_s, st_q.base_s};
        // Terminals seven and eight read zero as digital when used as analog
        dig_ins[6] = st_q.base_s[6] & ~analog_sel_i[0];
        dig_ins[7] = st_q.base_s[7] & ~analog_sel_i[1];
    end

    // Flat source vector seen by every gate input; blank outputs are absent
    always_comb begin
        src_vec = '0;
        src_vec[SRC_CONST_ZERO] = 1'b0;
        src_vec[SRC_CONST_ONE]  = 1'b1;
        src_vec[SRC_CURSOR_LSB +: NUM_CURSOR]     = st_q.cur_s;
        src_vec[SRC_SHIFT_LSB +: NUM_SHIFT_BITS]  = shift_bits_i;
        src_vec[SRC_INPUT_LSB +: NUM_DIG_INS]     = dig_ins;
        src_vec[SRC_FLAG_LSB +: NUM_DIG_FLAGS]    = st_q.flags;
    end

    // Gate input selection
    always_comb begin
        for (int g = 0; g < NUM_GATES; g++) begin
            for (int k = 0; k < GATE_INPUTS; k++) begin
                gopen[g][k] = (gate_cfg_i[g].src[k] == SRC_OPEN);
                gin[g][k]   = src_vec[gate_cfg_i[g].src[k]];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_GATES; gi++) begin : g_gate
            bgc_gate u_gate (
                .core_clk_i (core_clk_i),
                .reset_i    (reset_i),
                .cycle_i    (cycle_i && run_i),
                .kind_i     (gate_cfg_i[gi].kind),
                .in_i       (gin[gi]),
                .open_i     (gopen[gi]),
                .invert_i   (gate_cfg_i[gi].invert),
                .out_o      (gate_q[gi])
            );
        end
    endgenerate

    assign first_cycle = (st_q.run == BGC_FIRST);

    // Flag inputs: gate outputs by selection, plus program set/clear
    always_comb begin
        flag_next = st_q.flags;
        for (int f = 0; f < NUM_DIG_FLAGS; f++) begin
            if (flag_src_sel_i[f]) begin
                flag_next[f] = gate_q[f % NUM_GATES];
            end
        end
        if (flag_wr_i.en && flag_wr_i.idx < 5'(NUM_DIG_FLAGS)) begin
            flag_next[flag_wr_i.idx] = flag_wr_i.value;
        end
    end

    always_comb begin
        st_d = st_q;
        // Two-stage synchronisers for digital pins, four stages for analog pins
        st_d.base_m = base_in_i;
        st_d.base_s = st_q.base_m;
        st_d.exp_m  = exp_in_i;
        st_d.exp_s  = st_q.exp_m;
        st_d.cur_m  = cursor_i;
        st_d.cur_s  = st_q.cur_m;
        st_d.ana_m  = analog_pin_i;
        st_d.ana_p  = st_q.ana_m;
        st_d.ana_q  = st_q.ana_p;
        // A multi-bit word may tear across the sync; take it only once two samples agree
        if (st_q.ana_q == st_q.ana_p) begin
            st_d.ana_s = st_q.ana_q;
        end
        if (!run_i) begin
            st_d.run = BGC_STOP;
        end else if (cycle_i) begin
            // Flags sample at the cycle boundary and hold through the next
            st_d.flags  = flag_next;
            st_d.aflags = ana_flag_in_i;
            for (int o = 0; o < NUM_DIG_OUTS; o++) begin
                st_d.outs[o] = gate_q[out_gate_sel_i[o]];
            end
            for (int b = 0; b < NUM_BLANK_OUTS; b++) begin
                st_d.blank[b] = gate_q[blank_gate_sel_i[b]];
            end
            for (int a = 0; a < 2; a++) begin
                st_d.ach[a] = analog_sel_i[a] ? st_q.ana_s[a] : '0;
            end
            case (st_q.run)
                BGC_STOP: begin
                    st_d.run = BGC_FIRST;
                    st_d.flags[STARTUP_FLAG] = 1'b1;
                end
                BGC_FIRST: begin
                    st_d.run = BGC_RUN;
                    // Auto-clear unless the program writes it this cycle
                    if (!(flag_wr_i.en && flag_wr_i.idx == 5'(STARTUP_FLAG))) begin
                        st_d.flags[STARTUP_FLAG] = 1'b0;
                    end
                end
                BGC_RUN: st_d.run = BGC_RUN;
                default: st_d.run = BGC_STOP;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_q <= '0;
            st_q.flags <= FLAGS_RESET;
            st_q.run   <= BGC_STOP;
        end else begin
            st_q <= st_d;
        end
    end

    assign gate_out_o          = gate_q;
    assign base_out_o          = st_q.outs[NUM_BASE_OUTS-1:0];
    assign exp_out_o           = st_q.outs[NUM_DIG_OUTS-1:NUM_BASE_OUTS];
    assign flags_o             = st_q.flags;
    assign ana_flags_o         = st_q.aflags;
    assign analog_ch_o         = st_q.ach;
    assign first_cycle_pulse_o = first_cycle;
    assign run_state_o         = st_q.run;

endmodule

// ==== bgc_pkg.sv ====
// Package for the Boolean gate cycle evaluator: types and constants
package bgc_pkg;

    // Gate input count and connector sizes
    localparam int GATE_INPUTS    = 4;
    localparam int NUM_GATES      = 4;
    localparam int NUM_DIG_FLAGS  = 24;
    localparam int NUM_ANA_FLAGS  = 6;
    localparam int NUM_SHIFT_BITS = 8;
    localparam int NUM_DIG_OUTS   = 16;
    localparam int NUM_BLANK_OUTS = 16;
    localparam int NUM_CURSOR     = 4;
    localparam int NUM_BASE_INS   = 8;
    localparam int NUM_EXP_INS    = 16;
    localparam int NUM_DIG_INS    = NUM_BASE_INS + NUM_EXP_INS;
    localparam int NUM_BASE_OUTS  = 4;
    localparam int ANA_WIDTH      = 10;
    localparam int STARTUP_FLAG   = 7;

    // Source select code width: 6 bits index a flat source vector
    localparam int SRC_W = 6;
    localparam int SRC_N = 64;

    // Source vector layout (bit positions)
    localparam logic [SRC_W-1:0] SRC_CONST_ZERO = 6'h00;
    localparam logic [SRC_W-1:0] SRC_CONST_ONE  = 6'h01;
    localparam logic [SRC_W-1:0] SRC_CURSOR_LSB = 6'h02;
    localparam logic [SRC_W-1:0] SRC_SHIFT_LSB  = 6'h06;
    localparam logic [SRC_W-1:0] SRC_INPUT_LSB  = 6'h0E;
    localparam logic [SRC_W-1:0] SRC_FLAG_LSB   = 6'h26;
    localparam logic [SRC_W-1:0] SRC_OPEN       = 6'h3F;

    // Reset values
    localparam logic [NUM_DIG_FLAGS-1:0] FLAGS_RESET = 24'h000000;
    localparam logic [GATE_INPUTS-1:0]   HIST_RESET  = 4'h0;

    // Basic gate kinds
    typedef enum logic [2:0] {
        BGC_AND,
        BGC_AND_EDGE,
        BGC_NAND,
        BGC_NAND_EDGE,
        BGC_OR,
        BGC_NOR
    } bgc_kind_e;

    // Configuration of one gate
    typedef struct packed {
        bgc_kind_e                         kind;
        logic [GATE_INPUTS-1:0]            invert;
        logic [GATE_INPUTS-1:0][SRC_W-1:0] src;
    } bgc_gate_cfg_s;

    // Flag write command from the program
    typedef struct packed {
        logic                             en;
        logic [4:0]                       idx;
        logic                             value;
    } bgc_flag_wr_s;

    // Run state
    typedef enum logic [1:0] {
        BGC_STOP,
        BGC_FIRST,
        BGC_RUN
    } bgc_run_e;

endpackage

// ==== bgc_gate.sv ====
// One four-input basic gate with inversion, open-input defaults and edge history
`timescale 1ns/10ps
module bgc_gate
    import bgc_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_i,
    // Cycle control
    input  wire logic                   cycle_i,
    // Gate inputs
    input  wire bgc_kind_e              kind_i,
    input  wire logic [GATE_INPUTS-1:0] in_i,
    input  wire logic [GATE_INPUTS-1:0] open_i,
    input  wire logic [GATE_INPUTS-1:0] invert_i,
    // Result
    output logic                        out_o
);

    typedef struct packed {
        logic [GATE_INPUTS-1:0] hist;
        logic                   out;
    } bgc_gate_st_s;

    bgc_gate_st_s st_q;
    bgc_gate_st_s st_d;
    logic [GATE_INPUTS-1:0] eff;
    logic [GATE_INPUTS-1:0] andv;
    logic [GATE_INPUTS-1:0] orv;
    logic                   all_hi;
    logic                   any_hi;
    logic                   prev_all_hi;

    always_comb begin
        eff         = in_i ^ invert_i;
        andv        = eff | open_i;
        orv         = eff & ~open_i;
        all_hi      = &andv;
        any_hi      = |orv;
        prev_all_hi = &st_q.hist;
        st_d        = st_q;
        if (cycle_i) begin
            st_d.hist = andv;
            case (kind_i)
                BGC_AND:       st_d.out = all_hi;
                BGC_AND_EDGE:  st_d.out = all_hi & ~prev_all_hi;
                BGC_NAND:      st_d.out = ~all_hi;
                BGC_NAND_EDGE: st_d.out = ~all_hi & prev_all_hi;
                BGC_OR:        st_d.out = any_hi;
                BGC_NOR:       st_d.out = ~any_hi;
                default:       st_d.out = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_q <= '{hist: HIST_RESET, out: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign out_o = st_q.out;

endmodule

// ==== bgc_assertions.sv ====
// Concurrent checks on the Boolean gate cycle evaluator ports
`timescale 1ns/10ps
module bgc_assertions
    import bgc_pkg::*;
(
    // Clock, reset and cycle control
    input wire logic                          core_clk_i,
    input wire logic                          reset_i,
    input wire logic                          run_i,
    input wire logic                          cycle_i,
    // Configuration and flag writes
    input wire bgc_gate_cfg_s [NUM_GATES-1:0] gate_cfg_i,
    input wire bgc_flag_wr_s                  flag_wr_i,
    // Results
    input wire logic [NUM_GATES-1:0]          gate_out_o,
    input wire logic [NUM_DIG_FLAGS-1:0]      flags_o,
    input wire logic                          first_cycle_pulse_o,
    input wire bgc_run_e                      run_state_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire logic take = cycle_i && run_i;

    reset_clear_a: assert property (disable iff (1'b0) reset_i |=> run_state_o == BGC_STOP
        && flags_o == '0 && gate_out_o == '0 && !first_cycle_pulse_o) else $error("Reset left state behind");
    start_entry_a: assert property (take && run_state_o == BGC_STOP |=> run_state_o == BGC_FIRST)
        else $error("Strobe in stop did not enter the first cycle");
    first_pulse_a: assert property (run_state_o == BGC_FIRST |-> first_cycle_pulse_o
        && flags_o[STARTUP_FLAG]) else $error("Startup flag low in the first cycle");
    first_clear_a: assert property (take && run_state_o == BGC_FIRST |=> run_state_o == BGC_RUN
        && !first_cycle_pulse_o) else $error("First cycle did not end on the strobe");
    stop_return_a: assert property (!run_i |=> run_state_o == BGC_STOP) else $error("Run low but not stopped");
    hold_quiet_a: assert property (run_i && !cycle_i |=> $stable(flags_o) && $stable(gate_out_o))
        else $error("Results moved between strobes");
    and_zero_a: assert property (take && gate_cfg_i[0].kind == BGC_AND && !gate_cfg_i[0].invert[0]
        && gate_cfg_i[0].src[0] == SRC_CONST_ZERO |=> !gate_out_o[0]) else $error("AND high with a zero input");
    flag_write_a: assert property (take && run_state_o == BGC_RUN && flag_wr_i.en && flag_wr_i.idx < 5'h18
        |=> flags_o[$past(flag_wr_i.idx)] == $past(flag_wr_i.value)) else $error("Flag write lost");

    first_seen_c: cover property (take && run_state_o == BGC_FIRST);
    write_seen_c: cover property (take && flag_wr_i.en);
    edge_seen_c: cover property (take && gate_cfg_i[0].kind == BGC_AND_EDGE ##1 gate_out_o[0]);
endmodule

// ==== tb_bgc_top.sv ====
// Self-checking bench for the Boolean gate cycle evaluator
`timescale 1ns/10ps
module tb_bgc_top
    import bgc_pkg::*;
;
    logic                    core_clk_i = 1'b0;
    logic                    reset_i = 1'b1;
    logic                    run_i = 1'b0;
    logic                    cycle_i = 1'b0;
    logic                    first_cycle_pulse_o;
    bgc_gate_cfg_s [3:0]     gate_cfg_i = '0;
    bgc_flag_wr_s            flag_wr_i = '0;
    bgc_run_e                run_state_o;
    logic [3:0]              gate_out_o;
    logic [3:0]              cursor_i = '0;
    logic [3:0]              base_out_o;
    logic [7:0]              base_in_i = '0;
    logic [7:0]              shift_bits_i = '0;
    logic [15:0]             exp_in_i = '0;
    logic [11:0]             exp_out_o;
    logic [1:0]              analog_sel_i = '0;
    logic [1:0][9:0]         analog_pin_i = {10'h2A5, 10'h15A};
    logic [1:0][9:0]         analog_ch_o;
    logic [23:0]             flag_src_sel_i = '0;
    logic [23:0]             flags_o;
    logic [5:0][9:0]         ana_flag_in_i = {3{10'h0F0, 10'h30F}};
    logic [5:0][9:0]         ana_flags_o;
    logic [15:0][1:0]        out_gate_sel_i = {4{8'hE4}};
    logic [15:0][1:0]        blank_gate_sel_i = {4{8'h1B}};
    int                      fails = 0;
    int                      n_compared = 0;

    bgc_top u_dut (
        .core_clk_i          (core_clk_i),
        .reset_i             (reset_i),
        .run_i               (run_i),
        .cycle_i             (cycle_i),
        .gate_cfg_i          (gate_cfg_i),
        .base_in_i           (base_in_i),
        .exp_in_i            (exp_in_i),
        .cursor_i            (cursor_i),
        .analog_sel_i        (analog_sel_i),
        .analog_pin_i        (analog_pin_i),
        .shift_bits_i        (shift_bits_i),
        .flag_src_sel_i      (flag_src_sel_i),
        .flag_wr_i           (flag_wr_i),
        .ana_flag_in_i       (ana_flag_in_i),
        .out_gate_sel_i      (out_gate_sel_i),
        .blank_gate_sel_i    (blank_gate_sel_i),
        .gate_out_o          (gate_out_o),
        .base_out_o          (base_out_o),
        .exp_out_o           (exp_out_o),
        .flags_o             (flags_o),
        .ana_flags_o         (ana_flags_o),
        .analog_ch_o         (analog_ch_o),
        .first_cycle_pulse_o (first_cycle_pulse_o),
        .run_state_o         (run_state_o)
    );
    always #12.5 core_clk_i = ~core_clk_i;

    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One program cycle; a flag write rides on the strobe
    task automatic strobe(input bgc_flag_wr_s w);
        @(negedge core_clk_i);
        cycle_i = 1'b1;
        flag_wr_i = w;
        @(negedge core_clk_i);
        cycle_i = 1'b0;
        flag_wr_i = '0;
    endtask

    function automatic logic [23:0] one_src(input logic [5:0] s);
        return {SRC_OPEN, SRC_OPEN, SRC_OPEN, s};
    endfunction

    task automatic cfg(input int g, bgc_kind_e k, logic [3:0] inv, logic [23:0] s);
        gate_cfg_i[g] = {k, inv, s};
    endtask

    task automatic cfg_all(input logic [3:0] inv, logic [23:0] s);
        cfg(0, BGC_AND, inv, s);
        cfg(1, BGC_NAND, inv, s);
        cfg(2, BGC_OR, inv, s);
        cfg(3, BGC_NOR, inv, s);
    endtask

    task automatic t_startup();
        check("reset", {run_state_o, flags_o, gate_out_o, first_cycle_pulse_o}, '0);
        cfg(0, BGC_AND, 4'h0, one_src(SRC_FLAG_LSB + 6'h07));
        strobe('0);
        check("idle", run_state_o, BGC_STOP);
        run_i = 1'b1;
        strobe('0);
        check("first", {run_state_o, first_cycle_pulse_o, flags_o}, {BGC_FIRST, 1'b1, 24'h000080});
        check("flag lag", gate_out_o[0], 1'b0);
        repeat (3) @(negedge core_clk_i);
        check("flag hold", flags_o, 24'h000080);
        strobe('0);
        check("run", {run_state_o, first_cycle_pulse_o, flags_o}, {BGC_RUN, 1'b0, 24'h000000});
        check("flag seen", gate_out_o[0], 1'b1);
        strobe('{1'b1, 5'h07, 1'b1});
        strobe('{1'b1, 5'h18, 1'b1});
        check("flag write", flags_o, 24'h000080);
        strobe('{1'b1, 5'h07, 1'b0});
        check("flag clear", flags_o, 24'h000000);
        $display("Startup test done");
    endtask

    task automatic t_tables();
        logic [3:0] inv;
        logic [3:0] x;
        for (int p = 0; p < 2; p++) begin
            inv = {4{p[0]}};
            cfg_all(inv, {SRC_SHIFT_LSB + 6'h03, SRC_SHIFT_LSB + 6'h02, SRC_SHIFT_LSB + 6'h01, SRC_SHIFT_LSB});
            for (int c = 0; c < 16; c++) begin
                shift_bits_i = c[7:0];
                strobe('0);
                x = c[3:0] ^ inv;
                check("table", gate_out_o, {~|x, |x, ~&x, &x});
            end
        end
        for (int j = 0; j < 2; j++) begin
            cfg_all(4'h0, one_src(j ? SRC_CONST_ONE : SRC_CONST_ZERO));
            strobe('0);
            check("open", gate_out_o, j ? 4'h5 : 4'hA);
        end
        $display("Gate table test done");
    endtask

    task automatic t_edge();
        logic prev;
        logic cur;
        cfg(0, BGC_AND_EDGE, 4'h0, one_src(SRC_SHIFT_LSB));
        cfg(1, BGC_NAND_EDGE, 4'h0, one_src(SRC_SHIFT_LSB));
        shift_bits_i = 8'h00;
        strobe('0);
        prev = 1'b0;
        for (int i = 0; i < 6; i++) begin
            cur = (i inside {1, 2, 5});
            shift_bits_i = {7'h00, cur};
            strobe('0);
            check("edge", gate_out_o[1:0], {~cur & prev, cur & ~prev});
            prev = cur;
        end
        $display("Edge test done");
    endtask

    task automatic t_pins();
        base_in_i = 8'hFF;
        exp_in_i = 16'h0001;
        cursor_i = 4'h8;
        shift_bits_i = 8'h80;
        analog_sel_i = 2'b11;
        cfg(0, BGC_AND, 4'h0, one_src(SRC_INPUT_LSB + 6'h08));
        cfg(1, BGC_OR, 4'h0, one_src(SRC_INPUT_LSB + 6'h07));
        cfg(2, BGC_OR, 4'h0, one_src(SRC_CURSOR_LSB + 6'h03));
        cfg(3, BGC_OR, 4'h0, one_src(SRC_SHIFT_LSB + 6'h07));
        repeat (3) @(negedge core_clk_i);
        strobe('0);
        strobe('0);
        check("pins", gate_out_o, 4'hD);
        check("outs", {exp_out_o, base_out_o}, 16'hDDDD);
        check("analog", {ana_flags_o, analog_ch_o}, {ana_flag_in_i, analog_pin_i});
        analog_sel_i = 2'b00;
        flag_src_sel_i = 24'h00000F;
        strobe('0);
        strobe('0);
        check("digital", analog_ch_o, 20'h00000);
        check("terminal eight", gate_out_o, 4'hF);
        check("flag source", flags_o, 24'h00000F);
        run_i = 1'b0;
        @(negedge core_clk_i);
        check("stopped", run_state_o, BGC_STOP);
        shift_bits_i = 8'h00;
        strobe('0);
        check("stop hold", gate_out_o, 4'hF);
        $display("Pin and stop test done");
    endtask

    initial begin
        repeat (20) @(negedge core_clk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        t_startup();
        t_tables();
        t_edge();
        t_pins();
        close_out();
    end

    // The tests need well under 20 us
    initial begin
        #100000;
        fails++;
        close_out();
    end
endmodule

bind bgc_top bgc_assertions u_chk (
    .core_clk_i          (core_clk_i),
    .reset_i             (reset_i),
    .run_i               (run_i),
    .cycle_i             (cycle_i),
    .gate_cfg_i          (gate_cfg_i),
    .flag_wr_i           (flag_wr_i),
    .gate_out_o          (gate_out_o),
    .flags_o             (flags_o),
    .first_cycle_pulse_o (first_cycle_pulse_o),
    .run_state_o         (run_state_o)
);
